// ---- rtl/tcp_top.sv ----
`timescale 1ns/1ps
// Overview of operation
// - receiver runs all slots, accepts data only in enabled slots.
// - frame sync comes from internal generator or external pin.
// - external sync in multichannel: transmitter skips first sync pulse.
// - receiver starts shifting on the very first sync pulse.
// - enable-delay bit set adds delay before driving transmit pin.
// - delay touches only output enable, data timing unchanged.
// - up to 128 channels per frame, shared among devices.
// - 2-partition mode: each frame starts at A, then alternates B, A.
// - with selection on, at most 32 channels enabled per direction at once.
// - receive A field 0..3 selects even blocks 0,2,4,6.
// - receive B field 0..3 selects odd blocks 1,3,5,7.
// - transmit A field selects even blocks like receive.
// - transmit B field selects odd blocks like receive.
// - partition A enables in bits 0-15, B enables in bits 16-31.
// - block assignment may change while running.
// - disabled receive slots never reach read register or ready flag.
// - current block readable for both directions.
// - receive selection off means all receive channels enabled.
module tcp_top
	import tcp_pkg::*;
#(
	parameter int WORD_W = tcp_pkg::WORD_W_DEF,
	parameter int TX_OE_DELAY = tcp_pkg::TX_OE_DELAY_DEF
)(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic bit_clk,
	input wire logic frame_sync_in,
	output logic frame_sync_out,
	input wire logic serial_rx_data_pin,
	output logic serial_tx_data_pin,
	output logic serial_tx_data_oe
);
	import tcp_pkg::*;

	localparam int BW = (WORD_W > 1) ? $clog2(WORD_W) : 1;
	localparam logic [BW-1:0] LAST_BIT = BW'(WORD_W - 1);

	tcp_ctrl_t ctrl_ff;
	tcp_blksel_t blk_ff;
	logic [31:0] rx_chan_enable_ab_ff, tx_chan_enable_ab_ff;
	logic [WORD_W-1:0] tx_data_ff, rx_shift_buffer_ff, rx_read_reg_ff;
	logic rx_ready_flag_ff;
	logic [2:0] bclk_ff;
	logic [1:0] fsin_ff;
	logic [1:0] rxd_ff;
	logic active_ff, fs_out_ff, tx_seen_ff, tx_armed_ff;
	logic drive_ff, txd_ff, oe_ff;
	logic [CHAN_W-1:0] slot_ff;
	logic [BW-1:0] bit_ff;
	logic [7:0] dly_ff;
	logic [31:0] prdata_ff;

	// ****************************************
	// apb slave
	// ****************************************
	logic wr_w, rd_clr_w, mapped_w;
	assign wr_w = psel & penable & pwrite;
	assign rd_clr_w = psel & penable & ~pwrite & (paddr == RXDATA_OFS);
	assign mapped_w = paddr inside {CTRL_OFS, BLKSEL_OFS, RXEN_OFS,
		TXEN_OFS, TXDATA_OFS, RXDATA_OFS, STATUS_OFS};
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped_w;
	assign prdata = prdata_ff;

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ctrl_ff <= CTRL_RST;
			blk_ff <= BLKSEL_RST;
			rx_chan_enable_ab_ff <= CHEN_RST;
			tx_chan_enable_ab_ff <= CHEN_RST;
			tx_data_ff <= '0;
		end
		else if (wr_w)
		begin
			// assignments are live, taken at every slot
			case (paddr)
				CTRL_OFS: ctrl_ff <= pwdata;
				BLKSEL_OFS: blk_ff <= {24'h00_0000, pwdata[7:0]};
				RXEN_OFS: rx_chan_enable_ab_ff <= pwdata;
				TXEN_OFS: tx_chan_enable_ab_ff <= pwdata;
				TXDATA_OFS: tx_data_ff <= pwdata[WORD_W-1:0];
				default: ;
			endcase
		end
	end

	// read data latched in the setup cycle
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			prdata_ff <= '0;
		else if (psel & ~penable)
		begin
			prdata_ff <= '0;
			case (paddr)
				CTRL_OFS: prdata_ff <= {6'h00, ctrl_ff[25:24], 1'b0,
					ctrl_ff[22:16], 1'b0, ctrl_ff[14:0]};
				BLKSEL_OFS: prdata_ff <= {24'h00_0000, blk_ff[7:0]};
				RXEN_OFS: prdata_ff <= rx_chan_enable_ab_ff;
				TXEN_OFS: prdata_ff <= tx_chan_enable_ab_ff;
				TXDATA_OFS: prdata_ff[WORD_W-1:0] <= tx_data_ff;
				RXDATA_OFS: prdata_ff[WORD_W-1:0] <= rx_read_reg_ff;
				STATUS_OFS:
				begin
					prdata_ff[ST_RX_READY] <= rx_ready_flag_ff;
					prdata_ff[ST_RX_BLK_LSB +: 3] <= slot_ff[6:4];
					prdata_ff[ST_TX_BLK_LSB +: 3] <= slot_ff[6:4];
					prdata_ff[ST_TX_ARMED] <= tx_armed_ff;
					prdata_ff[ST_ACTIVE] <= active_ff;
				end
				default: ;
			endcase
		end
	end

	// ****************************************
	// link input synchronisers
	// ****************************************
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			// idle link clock stands high: no false edge after reset
			bclk_ff <= '1;
			fsin_ff <= '0;
			rxd_ff <= '0;
		end
		else
		begin
			bclk_ff <= {bclk_ff[1:0], bit_clk};
			fsin_ff <= {fsin_ff[0], frame_sync_in};
			rxd_ff <= {rxd_ff[0], serial_rx_data_pin};
		end
	end

	logic rise_w, fall_w, run_w, fs_evt_w, start_w, last_w, skip_w;
	logic rx_ok_w, tx_ok_w, tx_go_w, copy_w, frame_end_w;
	assign rise_w = bclk_ff[1] & ~bclk_ff[2];
	assign fall_w = ~bclk_ff[1] & bclk_ff[2];
	assign run_w = ctrl_ff.rx_enable | ctrl_ff.tx_enable;
	assign fs_evt_w = ctrl_ff.fs_internal ? fs_out_ff : fsin_ff[1];
	assign start_w = rise_w & run_w & fs_evt_w;
	assign last_w = bit_ff == LAST_BIT;
	assign frame_end_w = last_w &
		(slot_ff == ctrl_ff.rx_phase1_frame_length);
	assign skip_w = ~ctrl_ff.fs_internal & ctrl_ff.tx_chan_select_on;

	// ****************************************
	// channel selection
	// ****************************************
	// only 2-partition mapping is built; the count select bit is stored
	function automatic logic chan_ok(input logic [CHAN_W-1:0] ch,
		input logic mc, input logic [1:0] a, input logic [1:0] b,
		input logic [31:0] en);
		logic r;
		r = 1'b1;
		// one block per half, 32 channels at most
		if (mc)
		begin
			// even block 2*a is partition A
			// A enables low half, B enables high half
			if (!ch[4])
				r = (ch[6:5] == a) & en[{1'b0, ch[3:0]}];
			// odd block 2*b+1 is partition B
			else
				r = (ch[6:5] == b) & en[{1'b1, ch[3:0]}];
		end
		return r;
	endfunction

	assign rx_ok_w = chan_ok(slot_ff, ctrl_ff.rx_chan_select_on,
		blk_ff.rx_part_a_block_sel, blk_ff.rx_part_b_block_sel,
		rx_chan_enable_ab_ff);
	assign tx_ok_w = chan_ok(slot_ff, ctrl_ff.tx_chan_select_on,
		blk_ff.tx_part_a_block_sel, blk_ff.tx_part_b_block_sel,
		tx_chan_enable_ab_ff);
	assign tx_go_w = active_ff & tx_armed_ff & tx_ok_w &
		(slot_ff <= ctrl_ff.tx_phase1_frame_length);

	// ****************************************
	// frame timing
	// ****************************************
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			active_ff <= 1'b0;
			slot_ff <= '0;
			bit_ff <= '0;
		end
		else if (!run_w)
			active_ff <= 1'b0;
		// every sync restarts at slot 0, partition A
		else if (start_w)
		begin
			active_ff <= 1'b1;
			slot_ff <= '0;
			bit_ff <= '0;
		end
		// 7-bit slot count, up to 128 channels
		else if (rise_w & active_ff)
		begin
			bit_ff <= last_w ? '0 : bit_ff + 1'b1;
			if (frame_end_w)
				active_ff <= 1'b0;
			else if (last_w)
				slot_ff <= slot_ff + 1'b1;
		end
	end

	// internal sync at frame end or while idle, one bit period wide
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			fs_out_ff <= 1'b0;
		else if (fall_w)
			fs_out_ff <= ctrl_ff.fs_internal & run_w &
				(~active_ff | frame_end_w);
	end
	assign frame_sync_out = fs_out_ff;

	// ****************************************
	// receive path
	// ****************************************
	// disabled slots stop at the shift buffer
	// a sync on the last bit of a frame must still land that bit
	assign copy_w = rise_w & active_ff & last_w &
		ctrl_ff.rx_enable & rx_ok_w;

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rx_shift_buffer_ff <= '0;
			rx_read_reg_ff <= '0;
		end
		// shifting begins on the first sync
		else if (rise_w & active_ff)
		begin
			rx_shift_buffer_ff <= {rx_shift_buffer_ff[WORD_W-2:0],
				rxd_ff[1]};
			if (copy_w)
				rx_read_reg_ff <= {rx_shift_buffer_ff[WORD_W-2:0],
					rxd_ff[1]};
		end
	end

	// a new word beats a clearing read in the same cycle
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			rx_ready_flag_ff <= 1'b0;
		else if (copy_w)
			rx_ready_flag_ff <= 1'b1;
		else if (rd_clr_w)
			rx_ready_flag_ff <= 1'b0;
	end

	// ****************************************
	// transmit path
	// ****************************************
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			tx_seen_ff <= 1'b0;
			tx_armed_ff <= 1'b0;
		end
		else if (!ctrl_ff.tx_enable)
		begin
			tx_seen_ff <= 1'b0;
			tx_armed_ff <= 1'b0;
		end
		// external multichannel sync: the first pulse is only seen, the second arms
		else if (start_w & ~tx_armed_ff)
		begin
			tx_seen_ff <= 1'b1;
			tx_armed_ff <= ~skip_w | tx_seen_ff;
		end
	end

	// data changes on the falling bit clock edge
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			drive_ff <= 1'b0;
			txd_ff <= 1'b0;
		end
		else if (fall_w)
		begin
			drive_ff <= tx_go_w;
			txd_ff <= tx_data_ff[LAST_BIT - bit_ff];
		end
	end

	// hold-off loaded at the start of each driven run
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			dly_ff <= '0;
		else if (fall_w & tx_go_w & ~drive_ff &
			ctrl_ff.tx_line_enable_delay)
			dly_ff <= 8'(TX_OE_DELAY);
		else if (dly_ff != '0)
			dly_ff <= dly_ff - 1'b1;
	end

	// only the enable waits, so only the first bit is shortened
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			oe_ff <= 1'b0;
		else
			oe_ff <= drive_ff & (dly_ff == '0);
	end
	assign serial_tx_data_pin = txd_ff;
	assign serial_tx_data_oe = oe_ff;

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);

	AST_RX_READY_CAUSE: assert property (
		$rose(rx_ready_flag_ff) |-> $past(copy_w))
		else $error("ready rose without an enabled slot");
	AST_RX_DROP_DISABLED: assert property (
		rise_w & active_ff & ~start_w & last_w & ~rx_ok_w
		|=> rx_read_reg_ff == $past(rx_read_reg_ff))
		else $error("disabled slot reached read register");
	AST_RX_FIRST_SYNC: assert property (
		start_w & ctrl_ff.rx_enable
		|=> active_ff && slot_ff == '0 && bit_ff == '0)
		else $error("receiver missed first sync");
	AST_TX_SKIP_FIRST: assert property (
		start_w & skip_w & ctrl_ff.tx_enable & ~tx_seen_ff
		|=> tx_seen_ff && !tx_armed_ff)
		else $error("first external sync not skipped");
	AST_OE_HOLDOFF: assert property (
		$rose(drive_ff) & ctrl_ff.tx_line_enable_delay & (dly_ff != '0)
		|-> !oe_ff ##1 !oe_ff)
		else $error("enable not held off");
	AST_OE_NO_DELAY: assert property (
		$rose(drive_ff) & ~ctrl_ff.tx_line_enable_delay & (dly_ff == '0)
		|=> oe_ff)
		else $error("enable late without delay bit");
	AST_OE_ONLY_DRIVEN: assert property (
		fall_w & ~tx_go_w |-> ##2 !oe_ff)
		else $error("pin driven in disabled slot");
	AST_START_PART_A: assert property (
		start_w |=> slot_ff[4] == 1'b0)
		else $error("frame did not start in partition A");
	AST_RX_A_MAP: assert property (
		rx_ok_w & ctrl_ff.rx_chan_select_on & ~slot_ff[4]
		|-> slot_ff[6:5] == blk_ff.rx_part_a_block_sel)
		else $error("receive A block mismatch");
	AST_TX_B_MAP: assert property (
		tx_ok_w & ctrl_ff.tx_chan_select_on & slot_ff[4]
		|-> slot_ff[6:5] == blk_ff.tx_part_b_block_sel)
		else $error("transmit B block mismatch");
	AST_RX_ALL_ON: assert property (
		!ctrl_ff.rx_chan_select_on |-> rx_ok_w)
		else $error("channel disabled with selection off");

	COV_RX_COPY: cover property (copy_w);
	COV_TX_ARMED: cover property ($rose(tx_armed_ff) & skip_w);
	COV_OE_DELAYED: cover property ($rose(oe_ff) &
		ctrl_ff.tx_line_enable_delay);
	COV_INT_SYNC: cover property (start_w & ctrl_ff.fs_internal);
endmodule

// ---- rtl/tcp_pkg.sv ----
package tcp_pkg;
	// ****************************************
	// register map
	// ****************************************
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] BLKSEL_OFS = 8'h04;
	localparam logic [7:0] RXEN_OFS = 8'h08;
	localparam logic [7:0] TXEN_OFS = 8'h0c;
	localparam logic [7:0] TXDATA_OFS = 8'h10;
	localparam logic [7:0] RXDATA_OFS = 8'h14;
	localparam logic [7:0] STATUS_OFS = 8'h18;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] BLKSEL_RST = 32'h0000_0000;
	localparam logic [31:0] CHEN_RST = 32'h0000_0000;
	// status field positions
	localparam int ST_RX_READY = 0;
	localparam int ST_RX_BLK_LSB = 4;
	localparam int ST_TX_BLK_LSB = 8;
	localparam int ST_TX_ARMED = 12;
	localparam int ST_ACTIVE = 13;
	// ****************************************
	// timing and size
	// ****************************************
	localparam int WORD_W_DEF = 8;
	localparam int TX_OE_DELAY_DEF = 2;
	localparam int CHAN_W = 7;

	typedef struct packed {
		logic [5:0] rsv_hi;
		logic tx_phase_count_sel;
		logic rx_phase_count_sel;
		logic rsv_b23;
		logic [6:0] tx_phase1_frame_length;
		logic rsv_b15;
		logic [6:0] rx_phase1_frame_length;
		logic tx_partition_count_sel;
		logic rx_partition_count_sel;
		logic tx_chan_select_on;
		logic rx_chan_select_on;
		logic fs_internal;
		logic tx_line_enable_delay;
		logic tx_enable;
		logic rx_enable;
	} tcp_ctrl_t;

	typedef struct packed {
		logic [23:0] rsv;
		logic [1:0] tx_part_b_block_sel;
		logic [1:0] tx_part_a_block_sel;
		logic [1:0] rx_part_b_block_sel;
		logic [1:0] rx_part_a_block_sel;
	} tcp_blksel_t;
endpackage

// ---- verif/tcp_far_end.sv ----
`timescale 1ns/1ps
// ****************************************
// far-end tdm device
// ****************************************
module tcp_far_end (
	output logic bit_clk,
	output logic frame_sync_in,
	output logic serial_rx_data_pin,
	input wire logic serial_tx_data_pin,
	input wire logic serial_tx_data_oe,
	output logic [7:0] cur_slot
);
	logic [7:0] tx_word [0:127];
	logic oe_first [0:127];
	logic oe_last [0:127];

	function automatic logic [7:0] rx_word(input logic [7:0] s);
		rx_word = s * 8'h1d + 8'h07;
	endfunction

	// clock stands high between frames
	initial
	begin
		bit_clk = 1'b1;
		frame_sync_in = 1'b0;
		serial_rx_data_pin = 1'b0;
		cur_slot = 8'h00;
	end

	// external one-bit sync before slot 0
	// tx line only sampled here, never driven
	task automatic run_frame(input int nslots);
		logic [7:0] w;
		begin
			w = 8'h00;
			#7;
			bit_clk = 1'b0;
			frame_sync_in = 1'b1;
			#160;
			bit_clk = 1'b1;
			#160;
			for (int s = 0; s < nslots; s++)
			begin
				cur_slot = s[7:0];
				w = rx_word(s[7:0]);
				for (int b = 7; b >= 0; b--)
				begin
					bit_clk = 1'b0;
					frame_sync_in = 1'b0;
					serial_rx_data_pin = w[b];
					#160;
					bit_clk = 1'b1;
					// early look catches a held-off enable
					#20;
					if (b == 7)
						oe_first[s] = serial_tx_data_oe;
					#120;
					tx_word[s][b] = serial_tx_data_pin;
					if (b == 0)
						oe_last[s] = serial_tx_data_oe;
					#20;
				end
			end
			// released line shows the inverse of the last bit
			serial_rx_data_pin = ~w[0];
		end
	endtask
endmodule

// ---- verif/tdm_channel_partition_select_bench.sv ----
`timescale 1ns/1ps
module tdm_channel_partition_select_bench;
	import tcp_pkg::*;
	logic core_clk, rst_b, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0] paddr, cur_slot;
	logic [31:0] pwdata, prdata, q;
	logic bit_clk, frame_sync_in, rx_pin, tx_pin, tx_oe, fs_out, fs_prev;
	int n_fail, samples_checked, k, ta, tb, rc, n_fs;
	logic on;
	tcp_ctrl_t c;
	tcp_blksel_t bs;

	always #20 core_clk = ~core_clk;

	// counts internal sync pulses on the output pin
	always @(posedge core_clk)
	begin
		fs_prev <= fs_out;
		if (fs_out && !fs_prev)
			n_fs <= n_fs + 1;
	end

	tcp_top #(.WORD_W(8), .TX_OE_DELAY(2)) DUT (.core_clk(core_clk),
		.rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .bit_clk(bit_clk), .frame_sync_in(frame_sync_in),
		.frame_sync_out(fs_out), .serial_rx_data_pin(rx_pin),
		.serial_tx_data_pin(tx_pin), .serial_tx_data_oe(tx_oe));

	tcp_far_end far (.bit_clk(bit_clk), .frame_sync_in(frame_sync_in),
		.serial_rx_data_pin(rx_pin), .serial_tx_data_pin(tx_pin),
		.serial_tx_data_oe(tx_oe), .cur_slot(cur_slot));

	// ****************************************
	// helpers
	// ****************************************
	task automatic stop_test;
		$display("checks %0d failures %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	task automatic hang;
		n_fail++;
		$display("mismatch at %0t: wait ran out", $time);
		stop_test();
	endtask

	// setup cycle, then access until pready; release after
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		begin
			psel <= 1'b1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge core_clk);
			penable <= 1'b1;
			n = 0;
			do
			begin
				@(posedge core_clk);
				n++;
			end
			while (pready !== 1'b1 && n < 50);
			if (pready !== 1'b1)
				hang();
			q = prdata;
			err = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
			@(posedge core_clk);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a);
		apb(1'b0, a, 32'h0000_0000);
	endtask

	// status polled while slot 72 passes
	task automatic mid_status;
		int n;
		begin
			n = 0;
			while (cur_slot !== 8'd72 && n < 20000)
			begin
				@(posedge core_clk);
				n++;
			end
			if (n >= 20000)
				hang();
			rd(STATUS_OFS);
			check(q & 32'h0000_0770, 32'h0000_0440);
		end
	endtask

	initial
	begin
		#3990000;
		hang();
	end

	// ****************************************
	// main sequence
	// ****************************************
	initial
	begin
		core_clk = 1'b0;
		rst_b = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		n_fail = 0;
		samples_checked = 0;
		n_fs = 0;
		repeat (20) @(posedge core_clk);
		rst_b <= 1'b1;
		@(posedge core_clk);
		rd(BLKSEL_OFS);
		check(q, BLKSEL_RST);
		rd(TXEN_OFS);
		check(q, CHEN_RST);
		rd(STATUS_OFS);
		check(q, 32'h0000_0000);
		rd(8'h1c);
		check({31'h0, err}, 32'h0000_0001);
		check(q, 32'h0000_0000);
		wr(BLKSEL_OFS, 32'hffff_ffff);
		rd(BLKSEL_OFS);
		check(q, 32'h0000_00ff);
		// single phase, 128 slots, two partitions
		c = '0;
		c.rx_enable = 1'b1;
		c.tx_enable = 1'b1;
		c.rx_chan_select_on = 1'b1;
		c.tx_chan_select_on = 1'b1;
		c.rx_phase1_frame_length = 7'd127;
		c.tx_phase1_frame_length = 7'd127;
		wr(TXDATA_OFS, 32'h0000_00a5);
		for (int f = 0; f < 8; f++)
		begin
			k = (f * 5) % 16;
			ta = 32 * (f % 4) + k;
			tb = 32 * ((f + 1) % 4) + 16 + k;
			rc = (f < 4) ? 32 * f + k : 32 * (f - 4) + 16 + k;
			bs = '0;
			bs.rx_part_a_block_sel = f[1:0];
			bs.rx_part_b_block_sel = f[1:0];
			bs.tx_part_a_block_sel = f[1:0];
			bs.tx_part_b_block_sel = f[1:0] + 2'd1;
			wr(BLKSEL_OFS, bs);
			wr(RXEN_OFS, (f < 4) ? 32'h1 << k : 32'h1 << (16 + k));
			wr(TXEN_OFS, (32'h1 << k) | (32'h1 << (16 + k)));
			c.tx_line_enable_delay = f[0];
			wr(CTRL_OFS, c);
			if (f == 0)
			begin
				rd(STATUS_OFS);
				check({31'h0, q[ST_TX_ARMED]}, 32'h0000_0000);
			end
			fork
				far.run_frame(128);
				mid_status();
			join
			rd(STATUS_OFS);
			check({31'h0, q[ST_RX_READY]}, 32'h0000_0001);
			check({31'h0, q[ST_TX_ARMED]}, {31'h0, f > 0});
			rd(RXDATA_OFS);
			check(q & 32'hff, {24'h0, far.rx_word(rc[7:0])});
			rd(STATUS_OFS);
			check({31'h0, q[ST_RX_READY]}, 32'h0000_0000);
			for (int s = 0; s < 128; s++)
			begin
				on = (f > 0) && (s == ta || s == tb);
				check({31'h0, far.oe_last[s]}, {31'h0, on});
				if (on)
				begin
					check({24'h0, far.tx_word[s]}, 32'h0000_00a5);
					check({31'h0, far.oe_first[s]}, {31'h0, ~f[0]});
				end
			end
		end
		// selection off: every receive slot lands, 40-slot frame
		c.rx_chan_select_on = 1'b0;
		c.rx_phase1_frame_length = 7'd39;
		c.tx_phase1_frame_length = 7'd39;
		c.tx_line_enable_delay = 1'b0;
		bs.tx_part_a_block_sel = 2'd1;
		wr(BLKSEL_OFS, bs);
		wr(RXEN_OFS, 32'h0000_0000);
		wr(TXEN_OFS, 32'h0000_0201);
		wr(CTRL_OFS, c);
		far.run_frame(48);
		rd(RXDATA_OFS);
		check(q & 32'hff, {24'h0, far.rx_word(8'd39)});
		check({31'h0, far.oe_last[32]}, 32'h0000_0001);
		check({31'h0, far.oe_last[41]}, 32'h0000_0000);
		// software reset, then internal sync on a 39-slot frame
		wr(CTRL_OFS, 32'h0000_0000);
		c.fs_internal = 1'b1;
		c.rx_phase1_frame_length = 7'd38;
		c.tx_phase1_frame_length = 7'd38;
		wr(CTRL_OFS, c);
		k = n_fs;
		far.run_frame(39);
		// one sync before slot 0, one more at frame end
		check(n_fs - k, 32'd2);
		rd(RXDATA_OFS);
		check(q & 32'hff, {24'h0, far.rx_word(8'd38)});
		check({31'h0, far.oe_last[32]}, 32'h0000_0001);
		stop_test();
	end
endmodule
